// file: ses_slave_end.sv
`timescale 1ns/1ps
// What this block does
// - data falling while clock high starts command
// - data rising while clock high ends command
// - master keeps data steady while clock high
// - ignore the bus until a start
// - answer only to prefix 1010
// - next three bits: straps or internal address
// - eighth bit: one reads, zero writes
// - acknowledge matched address in ninth clock
// - acknowledge word address; acknowledge written data only while protect is low
// - send bytes while master keeps acknowledging
// - master ends read with no acknowledge, stop
// - sample on rising, change after falling clock
// - pull data low only, never drive high
// - master alone makes clock, start, stop
// - master begins only on idle bus
// - write protect high blocks writes, default low
// - undriven straps read as low
// - power good low resets, high enters standby
// - accept commands within one millisecond
// - filter pulses up to 100 ns
// - answer nothing during internal write cycle
// - sample protect before first data byte
module ses_slave_end #(
  parameter int INT_ADDR_BITS = 0,
  parameter int PU_CYC = ses_pkg::PU_CYC,
  parameter int WR_CYC = ses_pkg::WR_CYC
) (
  // link clock and reset
  input wire logic i_link_clk,
  input wire logic i_rstn,
  // supply monitor, straps, protect
  input wire logic i_power_good,
  input wire logic [2:0] i_strap_address_inputs,
  input wire logic i_write_protect,
  // two-wire bus
  ses_if.slv bus,
  // received bytes
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_rx_is_word_addr,
  output logic [2:0] o_ext_addr,
  output logic o_write_commit,
  // bytes to send
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_take,
  // status
  output logic o_busy
);
  localparam logic [2:0] CMP_MASK = 3'(3'h7 << INT_ADDR_BITS);
  localparam logic [3:0] BIT_LAST = 4'(ses_pkg::BYTE_BITS - 1);
  localparam logic [3:0] BIT_FULL = 4'(ses_pkg::BYTE_BITS);
  ses_pkg::ses_slv_state_t state_r;
  ses_pkg::ses_phase_t phase_r;
  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;
  logic [4:0] meta_r;
  logic [4:0] stat_r;
  logic pg_s;
  logic wp_s;
  logic [2:0] strap_s;
  logic [31:0] busy_cnt_r;
  logic busy;
  logic [3:0] bit_cnt_r;
  logic [7:0] sr_r;
  logic rw_r;
  logic sda_oe_r;
  logic wp_block_r;
  logic wr_pend_r;
  logic mst_ack_r;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_ok;
  logic byte_ack;
  // ==========================================================
  // filtered bus inputs and edge detection
  ses_glitch_filt #(.CYC(ses_pkg::FILT_CYC)) u_scl_filt (
    .i_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_pin(bus.scl),
    .o_level(scl_f)
  );
  ses_glitch_filt #(.CYC(ses_pkg::FILT_CYC)) u_sda_filt (
    .i_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_pin(bus.sda),
    .o_level(sda_f)
  );
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end
  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_ev = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_ev = scl_f & scl_d_r & ~sda_d_r & sda_f;
  // ==========================================================
  // static inputs; zero until sampled so undriven reads low
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 5'h00;
      stat_r <= 5'h00;
    end else begin
      meta_r <= {i_power_good, i_write_protect, i_strap_address_inputs};
      stat_r <= meta_r;
    end
  end
  assign pg_s = stat_r[4];
  assign wp_s = stat_r[3];
  assign strap_s = stat_r[2:0];
  // ==========================================================
  // shared busy timer: power-up delay, then internal write cycle
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_cnt_r <= 32'h0;
    end else if (!pg_s) begin
      busy_cnt_r <= 32'(PU_CYC);
    end else if (stop_ev && wr_pend_r) begin
      busy_cnt_r <= 32'(WR_CYC);
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r - 32'h1;
    end
  end
  assign busy = (busy_cnt_r != 32'h0);
  assign o_busy = busy;
  // ==========================================================
  // address match and acknowledge decision
  assign addr_ok = (sr_r[7:4] == ses_pkg::DEV_PREFIX)
    && (((sr_r[3:1] ^ strap_s) & CMP_MASK) == 3'h0)
    && !busy;
  always_comb begin
    case (phase_r)
      ses_pkg::PH_DEV: byte_ack = addr_ok;
      ses_pkg::PH_WORD: byte_ack = 1'b1;
      default: byte_ack = !wp_block_r;
    endcase
  end
  // ==========================================================
  // bit engine
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ses_pkg::SL_IDLE;
      phase_r <= ses_pkg::PH_DEV;
      bit_cnt_r <= 4'h0;
      sr_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wp_block_r <= 1'b0;
      wr_pend_r <= 1'b0;
      mst_ack_r <= 1'b0;
      o_ext_addr <= 3'h0;
    end else if (!pg_s) begin
      state_r <= ses_pkg::SL_IDLE;
      sda_oe_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= ses_pkg::SL_RX;
      phase_r <= ses_pkg::PH_DEV;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      wp_block_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else if (stop_ev) begin
      state_r <= ses_pkg::SL_IDLE;
      sda_oe_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else begin
      case (state_r)
        ses_pkg::SL_RX: begin
          if (scl_rise) begin
            sr_r <= {sr_r[6:0], sda_f};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BIT_FULL) begin
            if (phase_r == ses_pkg::PH_DEV) begin
              rw_r <= sr_r[0];
              o_ext_addr <= sr_r[3:1];
            end
            if (byte_ack) begin
              state_r <= ses_pkg::SL_RX_ACK;
              sda_oe_r <= 1'b1;
            end else begin
              state_r <= ses_pkg::SL_IDLE;
            end
          end
        end
        ses_pkg::SL_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (phase_r == ses_pkg::PH_DEV && rw_r) begin
              state_r <= ses_pkg::SL_TX;
              sr_r <= i_tx_byte;
              sda_oe_r <= ~i_tx_byte[7];
            end else begin
              state_r <= ses_pkg::SL_RX;
              sda_oe_r <= 1'b0;
              if (phase_r == ses_pkg::PH_DEV) begin
                phase_r <= ses_pkg::PH_WORD;
              end else if (phase_r == ses_pkg::PH_WORD) begin
                phase_r <= ses_pkg::PH_DATA;
                wp_block_r <= wp_s;
              end else begin
                wr_pend_r <= 1'b1;
              end
            end
          end
        end
        ses_pkg::SL_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == BIT_LAST) begin
              state_r <= ses_pkg::SL_TX_ACK;
              sda_oe_r <= 1'b0;
            end else begin
              sr_r <= {sr_r[6:0], 1'b0};
              sda_oe_r <= ~sr_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ses_pkg::SL_TX_ACK: begin
          if (scl_rise) begin
            mst_ack_r <= ~sda_f;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (mst_ack_r) begin
              state_r <= ses_pkg::SL_TX;
              sr_r <= i_tx_byte;
              sda_oe_r <= ~i_tx_byte[7];
            end else begin
              state_r <= ses_pkg::SL_IDLE;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end
  // ==========================================================
  // user-side pulses
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_is_word_addr <= 1'b0;
      o_tx_take <= 1'b0;
      o_write_commit <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_tx_take <= 1'b0;
      o_write_commit <= pg_s && stop_ev && wr_pend_r;
      if (pg_s && !start_ev && !stop_ev
          && state_r == ses_pkg::SL_RX && scl_fall
          && bit_cnt_r == BIT_FULL && byte_ack
          && phase_r != ses_pkg::PH_DEV) begin
        o_rx_byte <= sr_r;
        o_rx_valid <= 1'b1;
        o_rx_is_word_addr <= (phase_r == ses_pkg::PH_WORD);
      end
      if (pg_s && !start_ev && !stop_ev && scl_fall
          && ((state_r == ses_pkg::SL_RX_ACK
               && phase_r == ses_pkg::PH_DEV && rw_r)
              || (state_r == ses_pkg::SL_TX_ACK && mst_ack_r))) begin
        o_tx_take <= 1'b1;
      end
    end
  end
  // open drain: only ever pulls low
  assign bus.slv_sda_o = 1'b0;
  assign bus.slv_sda_oe = sda_oe_r;
endmodule : ses_slave_end

// file: ses_pkg.sv
package ses_pkg;
  // ==========================================================
  // addressing
  localparam logic [3:0] DEV_PREFIX = 4'hA;
  localparam int BYTE_BITS = 8;
  localparam int EXT_BITS = 3;
  // ==========================================================
  // timing
  localparam int LINK_PERIOD_PS = 15000;
  localparam int REF_PERIOD_PS = 4000;
  localparam int GLITCH_NS = 100;
  // two extra samples cover a pulse that straddles the sample grid
  localparam int FILT_CYC = (GLITCH_NS * 1000) / LINK_PERIOD_PS + 2;
  localparam int POWER_UP_DELAY_MS = 1;
  localparam longint PU_CYC_L =
    (64'(POWER_UP_DELAY_MS) * 64'd1000000000) / 64'(LINK_PERIOD_PS);
  localparam int PU_CYC = int'(PU_CYC_L);
  localparam int WRITE_CYCLE_MS = 5;
  localparam longint WR_CYC_L =
    (64'(WRITE_CYCLE_MS) * 64'd1000000000) / 64'(LINK_PERIOD_PS);
  localparam int WR_CYC = int'(WR_CYC_L);
  localparam int T_LOW_NS = 1300;
  // a clock quarter; two quarters make the low phase
  localparam int SCL_QTR_CYC =
    (T_LOW_NS * 500 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
  // ==========================================================
  // state encodings
  typedef enum logic [2:0] {
    SL_IDLE = 3'h0, SL_RX = 3'h1, SL_RX_ACK = 3'h3,
    SL_TX = 3'h2, SL_TX_ACK = 3'h6
  } ses_slv_state_t;
  typedef enum logic [1:0] {
    PH_DEV = 2'h0, PH_WORD = 2'h1, PH_DATA = 2'h3
  } ses_phase_t;
  typedef enum logic [2:0] {
    MS_IDLE = 3'h0, MS_START = 3'h1, MS_BITS = 3'h3,
    MS_HOLD = 3'h2, MS_STOP = 3'h6
  } ses_mst_state_t;
endpackage : ses_pkg

// file: ses_if.sv
`timescale 1ns/1ps
interface ses_if;
  // ==========================================================
  // drivers of the two open-drain wires
  logic scl_o;
  logic scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic slv_sda_o;
  logic slv_sda_oe;
  // ==========================================================
  // resolved wire levels, pulled up when nobody pulls low
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((mst_sda_oe & ~mst_sda_o) | (slv_sda_oe & ~slv_sda_o));
  modport slv (
    input scl,
    input sda,
    output slv_sda_o,
    output slv_sda_oe
  );
  modport mst (
    input scl,
    input sda,
    output scl_o,
    output scl_oe,
    output mst_sda_o,
    output mst_sda_oe
  );
endinterface : ses_if

// file: ses_glitch_filt.sv
`timescale 1ns/1ps
module ses_glitch_filt #(
  parameter int CYC = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // raw pin and filtered level
  input wire logic i_pin,
  output logic o_level
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic meta_r;
  logic sync_r;
  logic [CW-1:0] cnt_r;
  // ==========================================================
  // synchroniser; idle bus is high
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
    end
  end
  // ==========================================================
  // a new level must hold for CYC samples before it is taken
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      o_level <= 1'b1;
    end else if (sync_r == o_level) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      o_level <= sync_r;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
endmodule : ses_glitch_filt

// file: ses_master_end.sv
`timescale 1ns/1ps
module ses_master_end #(
  parameter int QTR_CYC = ses_pkg::SCL_QTR_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // command
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_start,
  input wire logic i_cmd_stop,
  input wire logic i_cmd_read,
  input wire logic i_cmd_mst_ack,
  input wire logic [7:0] i_cmd_byte,
  // response
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_byte,
  output logic o_rsp_not_acknowledged,
  output logic o_bus_busy,
  // two-wire bus
  ses_if.mst bus
);
  localparam int DW = $clog2(QTR_CYC + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(QTR_CYC - 1);
  localparam logic [3:0] BIT_ACK = 4'(ses_pkg::BYTE_BITS);
  ses_pkg::ses_mst_state_t state_r;
  logic meta_r;
  logic sda_s;
  logic [DW-1:0] div_r;
  logic [1:0] qtr_r;
  logic tick;
  logic take;
  logic [3:0] bit_r;
  logic [7:0] sr_r;
  logic stop_r;
  logic read_r;
  logic ack_r;
  logic nack_r;
  logic scl_oe_r;
  logic sda_oe_r;
  // ==========================================================
  // bus data synchroniser and quarter-period divider
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      meta_r <= bus.sda;
      sda_s <= meta_r;
    end
  end
  assign tick = (div_r == DIV_LAST);
  // begins only from a taken start on an idle bus
  assign o_cmd_ready = (state_r == ses_pkg::MS_HOLD)
    || (state_r == ses_pkg::MS_IDLE && sda_s);
  assign take = i_cmd_valid && o_cmd_ready;
  assign o_bus_busy = (state_r != ses_pkg::MS_IDLE);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_r <= '0;
      qtr_r <= 2'h0;
    end else if (take || tick) begin
      div_r <= '0;
      qtr_r <= take ? 2'h0 : qtr_r + 2'h1;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end
  // ==========================================================
  // sequencer; this end alone makes clock, start and stop
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ses_pkg::MS_IDLE;
      bit_r <= 4'h0;
      sr_r <= 8'h00;
      stop_r <= 1'b0;
      read_r <= 1'b0;
      ack_r <= 1'b0;
      nack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_byte <= 8'h00;
      o_rsp_not_acknowledged <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      if (take) begin
        sr_r <= i_cmd_byte;
        stop_r <= i_cmd_stop;
        read_r <= i_cmd_read;
        ack_r <= i_cmd_mst_ack;
        bit_r <= 4'h0;
        if (state_r == ses_pkg::MS_IDLE || i_cmd_start) begin
          state_r <= ses_pkg::MS_START;
        end else begin
          state_r <= ses_pkg::MS_BITS;
        end
      end else if (tick) begin
        case (state_r)
          ses_pkg::MS_START: begin
            case (qtr_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1;
              default: begin
                scl_oe_r <= 1'b1;
                state_r <= ses_pkg::MS_BITS;
              end
            endcase
          end
          ses_pkg::MS_BITS: begin
            case (qtr_r)
              2'h0: begin
                // data moves only while the clock is low
                if (bit_r == BIT_ACK) begin
                  sda_oe_r <= read_r & ack_r;
                end else begin
                  sda_oe_r <= ~read_r & ~sr_r[7];
                end
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (bit_r == BIT_ACK) begin
                  nack_r <= sda_s;
                end else begin
                  sr_r <= {sr_r[6:0], sda_s};
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                if (bit_r == BIT_ACK) begin
                  o_rsp_valid <= 1'b1;
                  o_rsp_byte <= sr_r;
                  o_rsp_not_acknowledged <= nack_r;
                  state_r <= stop_r ? ses_pkg::MS_STOP
                                    : ses_pkg::MS_HOLD;
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            endcase
          end
          ses_pkg::MS_STOP: begin
            case (qtr_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0;
              default: state_r <= ses_pkg::MS_IDLE;
            endcase
          end
          default: begin
          end
        endcase
      end
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_r;
  assign bus.mst_sda_o = 1'b0;
  assign bus.mst_sda_oe = sda_oe_r;
endmodule : ses_master_end

// file: ses_chk.sv
`timescale 1ns/1ps
module ses_chk (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // bus wires and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic slv_sda_o,
  input wire logic slv_sda_oe
);
  // ==========================================================
  // frame tracking on the resolved wires
  logic scl_q_r, sda_q_r, in_frame_r, first_r, rise, start, stop;
  logic [3:0] bit_cnt_r;
  logic [7:0] addr_r;
  assign rise = scl & ~scl_q_r;
  assign start = scl & scl_q_r & sda_q_r & ~sda;
  assign stop = scl & scl_q_r & ~sda_q_r & sda;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_frame_r <= 1'b0;
    end else if (start | stop) begin
      in_frame_r <= start;
    end
  end
  // bit_cnt_r is the number of clock rises already seen in this byte
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt_r <= 4'h0;
      first_r <= 1'b1;
      addr_r <= 8'h00;
    end else if (start) begin
      bit_cnt_r <= 4'h0;
      first_r <= 1'b1;
    end else if (rise) begin
      bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
      first_r <= first_r & (bit_cnt_r != 4'h8);
      if (first_r && bit_cnt_r != 4'h8) begin
        addr_r <= {addr_r[6:0], sda};
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_slv_open_drain: assert property (slv_sda_oe |-> !slv_sda_o)
    else $error("slave drove data high");
  a_clk_open_drain: assert property (scl_oe |-> !scl_o)
    else $error("master drove clock high");
  a_drive_in_frame: assert property (slv_sda_oe |-> in_frame_r)
    else $error("slave drove outside a frame");
  a_hold_while_high: assert property (
    slv_sda_oe && scl |=> slv_sda_oe || !scl)
    else $error("slave released data while clock high");
  a_drive_min_len: assert property (
    $rose(slv_sda_oe) |-> slv_sda_oe [*8])
    else $error("slave drive too short");
  a_ack_ninth: assert property (
    rise && slv_sda_oe && (first_r || !addr_r[0]) |-> bit_cnt_r == 4'h8)
    else $error("slave acknowledge outside ninth clock");
  a_read_release: assert property (
    rise && !first_r && addr_r[0] && bit_cnt_r == 4'h8 |-> !slv_sda_oe)
    else $error("slave held data in read ninth clock");
  // bits two to eight of a byte: any change with the clock high is illegal
  a_data_stable: assert property (
    scl && scl_q_r && in_frame_r && bit_cnt_r >= 4'h2 |-> sda == sda_q_r)
    else $error("data moved while clock high inside a byte");
  a_begin_idle: assert property (
    start && !in_frame_r |-> !slv_sda_oe)
    else $error("transfer began while slave held the bus");
  a_prefix_nack: assert property (
    rise && first_r && bit_cnt_r == 4'h8 &&
    addr_r[7:4] != ses_pkg::DEV_PREFIX |-> !slv_sda_oe)
    else $error("slave answered a foreign prefix");
  c_addr_ack: cover property (rise && first_r && bit_cnt_r == 4'h8 &&
    slv_sda_oe);
  c_read_bit: cover property (rise && !first_r && addr_r[0] && slv_sda_oe);
  c_stop: cover property (in_frame_r && stop);
endmodule : ses_chk

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // stimulus, outputs, scoreboards
  logic i_ref_clk, i_link_clk, i_rstn, pg, wp, cv, cs, cp, cr, ca, rdy;
  logic rv, rn, bb, xv, xw, wc, tt, busy, nk;
  logic [2:0] st, ea, e;
  logic [3:0] p;
  logic [7:0] tx, cb, rb, xb, got, wa, d;
  logic [8:0] rxq[$];
  logic [7:0] sq[$];
  int n_errors = 0;
  int comparisons = 0;
  int commits = 0;
  int n;
  ses_if bus_if();
  ses_slave_end #(.INT_ADDR_BITS(1), .PU_CYC(50), .WR_CYC(400))
    ses_slave_end_i (.i_link_clk(i_link_clk), .i_rstn(i_rstn),
    .i_power_good(pg), .i_strap_address_inputs(st),
    .i_write_protect(wp), .bus(bus_if.slv), .o_rx_byte(xb),
    .o_rx_valid(xv), .o_rx_is_word_addr(xw), .o_ext_addr(ea),
    .o_write_commit(wc), .i_tx_byte(tx), .o_tx_take(tt), .o_busy(busy));
  ses_master_end #(.QTR_CYC(24)) ses_master_end_i (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_cmd_valid(cv), .o_cmd_ready(rdy),
    .i_cmd_start(cs), .i_cmd_stop(cp), .i_cmd_read(cr),
    .i_cmd_mst_ack(ca), .i_cmd_byte(cb), .o_rsp_valid(rv),
    .o_rsp_byte(rb), .o_rsp_not_acknowledged(rn), .o_bus_busy(bb),
    .bus(bus_if.mst));
  ses_chk ses_chk_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .scl(bus_if.scl), .sda(bus_if.sda), .scl_o(bus_if.scl_o),
    .scl_oe(bus_if.scl_oe), .slv_sda_o(bus_if.slv_sda_o),
    .slv_sda_oe(bus_if.slv_sda_oe));
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #1.3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  // the bench plays the user of the slave's data ports
  always @(negedge i_link_clk) begin
    if (xv === 1'b1) rxq.push_back({xw, xb});
    if (wc === 1'b1) commits++;
    if (tt === 1'b1) begin
      sq.push_back(tx);
      tx <= 8'($urandom);
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic give_up();
    check(16'h0, 16'h1);
    finish_test();
  endtask : give_up
  function automatic logic [7:0] dev(input logic [2:0] x, input logic r);
    return {ses_pkg::DEV_PREFIX, x, r};
  endfunction : dev
  task automatic cmd(input logic s, q, r, a, input logic [7:0] b);
    int j;
    @(negedge i_ref_clk);
    {cs, cp, cr, ca, cb} = {s, q, r, a, b};
    cv = 1'b1;
    for (j = 0; j < 4000 && rdy !== 1'b1; j++) @(negedge i_ref_clk);
    if (j == 4000) give_up();
    @(negedge i_ref_clk);
    cv = 1'b0;
    for (j = 0; j < 4000 && rv !== 1'b1; j++) @(negedge i_ref_clk);
    if (j == 4000) give_up();
    got = rb;
    nk = rn;
  endtask : cmd
  task automatic settle();
    int j;
    for (j = 0; j < 500 && bb !== 1'b0; j++) @(negedge i_ref_clk);
    if (j == 500) give_up();
    repeat (20) @(negedge i_link_clk);
  endtask : settle
  task automatic await_free();
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge i_link_clk);
    if (n == 2000) give_up();
  endtask : await_free
  task automatic wr(input logic [2:0] x, input logic dn);
    int c0;
    c0 = commits;
    wa = 8'($urandom);
    d = 8'($urandom);
    rxq.delete();
    cmd(1, 0, 0, 0, dev(x, 0));
    check(nk, 0);
    cmd(0, 0, 0, 0, wa);
    check(nk, 0);
    cmd(0, 1, 0, 0, d);
    check(nk, dn);
    settle();
    check(16'(rxq.size()), 16'(2 - dn));
    check(rxq[0], {1'b1, wa});
    if (!dn) check(rxq[1], {1'b0, d});
    check(16'(commits - c0), !dn);
  endtask : wr
  // ==========================================================
  // main sequence
  initial begin
    {cv, cs, cp, cr, ca, cb} = '0;
    {pg, wp, st, tx, i_rstn} = {1'b1, 1'b0, 3'h0, 8'h5A, 1'b0};
    n = $urandom(83);
    repeat (3) @(negedge i_link_clk);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_link_clk);
    check(busy, 1);
    await_free();
    check(n <= 60, 1);
    $display("power-up test done");
    repeat (2) begin
      wr(st, 0);
      await_free();
    end
    wr(st, 0);
    cmd(1, 1, 0, 0, dev(st, 0));
    check(nk, 1);
    await_free();
    cmd(1, 1, 0, 0, dev(st, 0));
    check(nk, 0);
    settle();
    $display("write and polling test done");
    wp = 1'b1;
    wr(st, 1);
    wp = 1'b0;
    $display("protect test done");
    // straps at 0 first stand for pins left undriven
    for (int i = 0; i < 6; i++) begin
      st = (i < 3) ? 3'h0 : 3'($urandom);
      repeat (4) @(negedge i_link_clk);
      e = st ^ 3'(1 << (i % 3));
      cmd(1, 1, 0, 0, dev(e, 0));
      check(nk, i % 3 != 0);
      if (i % 3 == 0) check(ea, e);
      p = 4'($urandom);
      if (p == ses_pkg::DEV_PREFIX) p = 4'h2;
      cmd(1, 1, 0, 0, {p, st, 1'b0});
      check(nk, 1);
    end
    settle();
    $display("address test done");
    cmd(1, 0, 0, 0, dev(st, 0));
    cmd(0, 0, 0, 0, wa);
    sq.delete();
    cmd(1, 0, 0, 0, dev(st, 1));
    check(nk, 0);
    for (int j = 0; j < 4; j++) begin
      cmd(0, j == 3, 1, j != 3, 8'h00);
      check(got, sq[j]);
      check(nk, j == 3);
    end
    settle();
    $display("read test done");
    pg = 1'b0;
    repeat (6) @(negedge i_link_clk);
    check(busy, 1);
    pg = 1'b1;
    await_free();
    check(n <= 60, 1);
    cmd(1, 1, 0, 0, dev(st, 0));
    check(nk, 0);
    settle();
    $display("brown-out test done");
    finish_test();
  end
endmodule : testbench
